// file: core/dpmb_host.sv
// Controller that drives one port of an asynchronous dual-port memory.
// Assumes software on a plain strobe port and the memory port on the pins.
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`include "dpmb_params.svh"

module dpmb_host
   import dpmb_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic [2:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output      logic [15:0] reg_rdata,
   output      logic [12:0] mem_addr,
   output      logic        chip_sel_n,
   output      logic        token_select_n,
   output      logic        rw_n,
   output      logic        out_en_n,
   output      logic        upper_lane_select_n,
   output      logic        lower_lane_select_n,
   input  wire logic [15:0] dq_i,
   output      logic [15:0] dq_o,
   output      logic        dq_oe_n,
   input  wire logic        busy_n,
   input  wire logic        flag_n
);

   localparam logic [7:0] ACCESS_CYC = 8'(`DPMB_ACCESS_CYC);
   localparam logic [7:0] WRITE_CYC  = 8'(`DPMB_WRITE_CYC);
   localparam logic [7:0] FLOW_CYC   = 8'(`DPMB_FLOW_CYC);
   localparam logic [7:0] SETTLE_CYC = 8'(`DPMB_SETTLE_CYC);
   localparam logic [7:0] GAP_CYC    = 8'(`DPMB_GAP_CYC);

   dpmb_regs_t r;
   dpmb_regs_t next_r;

   // Token operations use the token select
   function automatic logic is_token(input dpmb_op_t op);
      is_token = (op == DPMB_TOK_READ) || (op == DPMB_TOK_WRITE) || (op == DPMB_TOK_TAKE);
   endfunction : is_token

   // Whether the current access writes
   function automatic logic is_write(input dpmb_op_t op, input logic rd_phase);
      unique case (op)
         DPMB_MEM_WRITE: is_write = 1'b1;
         DPMB_TOK_WRITE: is_write = 1'b1;
         DPMB_TOK_TAKE:  is_write = !rd_phase;
         default:        is_write = 1'b0;
      endcase
   endfunction : is_write

   // Status word
   function automatic logic [15:0] status_word(input dpmb_regs_t s);
      status_word = 16'h0000;
      status_word[`DPMB_ST_ACTIVE] = s.active;
      status_word[`DPMB_ST_DONE]   = s.done;
      status_word[`DPMB_ST_OWNED]  = s.owned;
      status_word[`DPMB_ST_BUSY]   = !s.busy_s2;
      status_word[`DPMB_ST_FLAG]   = !s.flag_s2;
   endfunction : status_word

   logic tok;
   logic wr;

   always_comb begin
      tok = is_token(r.op);
      wr  = is_write(r.op, r.rd_phase);
   end

   always_comb begin
      next_r = r;

      // Pin synchronisers
      next_r.busy_s1 = busy_n;
      next_r.busy_s2 = r.busy_s1;
      next_r.flag_s1 = flag_n;
      next_r.flag_s2 = r.flag_s1;
      next_r.din_s1  = dq_i;
      next_r.din_s2  = r.din_s1;

      // Register reads answer one cycle later
      next_r.rd_data = 16'h0000;
      if (reg_rd) begin
         unique case (reg_addr)
            `DPMB_REG_CTRL:   next_r.rd_data = {10'h000, r.lane_en, 1'b0, r.op};
            `DPMB_REG_ADDR:   next_r.rd_data = {3'h0, r.addr};
            `DPMB_REG_WDATA:  next_r.rd_data = r.wdata;
            `DPMB_REG_RDATA:  next_r.rd_data = r.rdata;
            `DPMB_REG_STATUS: next_r.rd_data = status_word(r);
            default:          next_r.rd_data = 16'h0000;
         endcase
      end

      // Register writes; setup ignored while an access runs
      if (reg_wr && !r.active) begin
         unique case (reg_addr)
            `DPMB_REG_ADDR:  next_r.addr  = reg_wdata[12:0];
            `DPMB_REG_WDATA: next_r.wdata = reg_wdata;
            `DPMB_REG_CTRL: begin
               next_r.op       = dpmb_op_t'(reg_wdata[`DPMB_CTRL_OP_LSB +: 3]);
               next_r.lane_en  = reg_wdata[`DPMB_CTRL_LANE_LSB +: 2];
               next_r.rd_phase = 1'b0;
               next_r.active   = 1'b1;
               next_r.done     = 1'b0;
               next_r.st       = DPMB_SETUP;
               next_r.cnt      = SETTLE_CYC;
            end
            default: begin
            end
         endcase
      end

      unique case (r.st)
         DPMB_IDLE: begin
            next_r.chip_sel_n          = 1'b1;
            next_r.token_select_n      = 1'b1;
            next_r.rw_n                = 1'b1;
            next_r.out_en_n            = 1'b1;
            next_r.upper_lane_select_n = 1'b1;
            next_r.lower_lane_select_n = 1'b1;
            next_r.dq_oe_n             = 1'b1;
         end

         DPMB_SETUP: begin
            // Address, select and lanes stand before any strobe
            if (tok) begin
               next_r.token_select_n      = 1'b0;
               next_r.chip_sel_n          = 1'b1;
               next_r.upper_lane_select_n = 1'b1;
               next_r.lower_lane_select_n = 1'b1;
            end else begin
               next_r.chip_sel_n          = 1'b0;
               next_r.token_select_n      = 1'b1;
               next_r.upper_lane_select_n = !r.lane_en[1];
               next_r.lower_lane_select_n = !r.lane_en[0];
            end
            next_r.rw_n     = 1'b1;
            next_r.out_en_n = 1'b1;
            if (r.op == DPMB_TOK_TAKE) begin
               next_r.dq_o = 16'h0000;
            end else begin
               next_r.dq_o = r.wdata;
            end
            next_r.dq_oe_n = !wr;
            if (r.cnt > 8'h01) begin
               next_r.cnt = r.cnt - 8'h01;
            end else if (wr && !tok && !r.busy_s2) begin
               // A lost contention holds off the write until busy clears
               next_r.cnt = SETTLE_CYC;
            end else begin
               next_r.st  = DPMB_ACT;
               next_r.cnt = wr ? WRITE_CYC : ACCESS_CYC + FLOW_CYC;
            end
         end

         DPMB_ACT: begin
            if (wr) begin
               next_r.rw_n = 1'b0;
            end else begin
               next_r.out_en_n = 1'b0;
            end
            if (r.cnt > 8'h01) begin
               next_r.cnt = r.cnt - 8'h01;
            end else begin
               if (!wr) begin
                  next_r.rdata = r.din_s2;
               end
               // Rising read/write strobe ends the write
               next_r.rw_n     = 1'b1;
               next_r.out_en_n = 1'b1;
               next_r.st       = DPMB_HOLD;
            end
         end

         DPMB_HOLD: begin
            // Selects drop, data released after the strobe
            next_r.chip_sel_n          = 1'b1;
            next_r.token_select_n      = 1'b1;
            next_r.upper_lane_select_n = 1'b1;
            next_r.lower_lane_select_n = 1'b1;
            next_r.dq_oe_n             = 1'b1;
            next_r.st                  = DPMB_GAP;
            next_r.cnt                 = GAP_CYC;
            if (r.op == DPMB_TOK_TAKE && r.rd_phase) begin
               next_r.owned = !r.rdata[0];
            end else if (r.op == DPMB_TOK_READ) begin
               next_r.owned = !r.rdata[0];
            end else if (r.op == DPMB_TOK_WRITE && r.wdata[0]) begin
               // Writing one gives the latch away
               next_r.owned = 1'b0;
            end
         end

         DPMB_GAP: begin
            if (r.cnt > 8'h01) begin
               next_r.cnt = r.cnt - 8'h01;
            end else if (r.op == DPMB_TOK_TAKE && (!r.rd_phase || r.rdata[0])) begin
               // Read back, and keep polling while the far port owns it
               next_r.rd_phase = 1'b1;
               next_r.st       = DPMB_SETUP;
               next_r.cnt      = SETTLE_CYC;
            end else begin
               next_r.st     = DPMB_IDLE;
               next_r.active = 1'b0;
               next_r.done   = 1'b1;
            end
         end

         default: begin
            next_r.st     = DPMB_IDLE;
            next_r.active = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         r.st                  <= DPMB_IDLE;
         r.op                  <= DPMB_MEM_READ;
         r.rd_phase            <= 1'b0;
         r.cnt                 <= 8'h00;
         r.addr                <= `DPMB_ADDR_RST;
         r.wdata               <= `DPMB_DATA_RST;
         r.rdata               <= `DPMB_DATA_RST;
         r.lane_en             <= `DPMB_LANE_RST;
         r.active              <= 1'b0;
         r.done                <= 1'b0;
         r.owned               <= 1'b0;
         r.busy_s1             <= 1'b1;
         r.busy_s2             <= 1'b1;
         r.flag_s1             <= 1'b1;
         r.flag_s2             <= 1'b1;
         r.din_s1              <= 16'h0000;
         r.din_s2              <= 16'h0000;
         r.rd_data             <= 16'h0000;
         r.chip_sel_n          <= 1'b1;
         r.token_select_n      <= 1'b1;
         r.rw_n                <= 1'b1;
         r.out_en_n            <= 1'b1;
         r.upper_lane_select_n <= 1'b1;
         r.lower_lane_select_n <= 1'b1;
         r.dq_o                <= 16'h0000;
         r.dq_oe_n             <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   // Token accesses decode only the low address bits
   always_comb begin
      if (tok) begin
         mem_addr = {10'h000, r.addr[`DPMB_TOKEN_ADDR_W-1:0]};
      end else begin
         mem_addr = r.addr;
      end
   end

   assign reg_rdata           = r.rd_data;
   assign chip_sel_n          = r.chip_sel_n;
   assign token_select_n      = r.token_select_n;
   assign rw_n                = r.rw_n;
   assign out_en_n            = r.out_en_n;
   assign upper_lane_select_n = r.upper_lane_select_n;
   assign lower_lane_select_n = r.lower_lane_select_n;
   assign dq_o                = r.dq_o;
   assign dq_oe_n             = r.dq_oe_n;

endmodule : dpmb_host

// file: core/dpmb_params.svh
// Constants for the dual-port memory port controller.
// Assumes a 25 MHz clk and one asynchronous dual-port memory port on the pins.
// Operation
// - After a far-port write, wait the cross-port flow delay before trusting read data.
// - A memory read asserts both chip select and output enable.
// - A token read asserts token select instead of chip select, plus output enable.
// - Writes to a slave wait until its busy input has settled.
// - Request a token by writing zero, read back; zero means owned.
// - Release selects for the readback gap between token write and readback.
`ifndef DPMB_PARAMS_SVH
`define DPMB_PARAMS_SVH

`define DPMB_CLK_NS        40
`define DPMB_ACCESS_NS     55
`define DPMB_WRITE_NS      55
`define DPMB_FLOW_NS       55
`define DPMB_SETTLE_NS     45
`define DPMB_GAP_NS        15
`define DPMB_ACCESS_CYC    (((`DPMB_ACCESS_NS + `DPMB_CLK_NS - 1) / `DPMB_CLK_NS) + 2)
`define DPMB_WRITE_CYC     ((`DPMB_WRITE_NS + `DPMB_CLK_NS - 1) / `DPMB_CLK_NS)
`define DPMB_FLOW_CYC      ((`DPMB_FLOW_NS + `DPMB_CLK_NS - 1) / `DPMB_CLK_NS)
`define DPMB_SETTLE_CYC    (((`DPMB_SETTLE_NS + `DPMB_CLK_NS - 1) / `DPMB_CLK_NS) + 2)
`define DPMB_GAP_CYC       ((`DPMB_GAP_NS + `DPMB_CLK_NS - 1) / `DPMB_CLK_NS)

`define DPMB_REG_CTRL      3'h0
`define DPMB_REG_ADDR      3'h1
`define DPMB_REG_WDATA     3'h2
`define DPMB_REG_RDATA     3'h3
`define DPMB_REG_STATUS    3'h4

`define DPMB_CTRL_OP_LSB   0
`define DPMB_CTRL_LANE_LSB 4
`define DPMB_ST_ACTIVE     0
`define DPMB_ST_DONE       1
`define DPMB_ST_OWNED      2
`define DPMB_ST_BUSY       3
`define DPMB_ST_FLAG       4

`define DPMB_ADDR_RST      13'h0000
`define DPMB_DATA_RST      16'h0000
`define DPMB_LANE_RST      2'h3
`define DPMB_TOKEN_ADDR_W  3

`endif

// file: core/dpmb_pkg.sv
// Types for the dual-port memory port controller.
// Assumes the constants header is compiled alongside.
package dpmb_pkg;

   typedef enum logic [2:0] {
      DPMB_IDLE  = 3'h0,
      DPMB_SETUP = 3'h1,
      DPMB_ACT   = 3'h3,
      DPMB_HOLD  = 3'h2,
      DPMB_GAP   = 3'h6
   } dpmb_state_t;

   typedef enum logic [2:0] {
      DPMB_MEM_READ  = 3'h0,
      DPMB_MEM_WRITE = 3'h1,
      DPMB_TOK_READ  = 3'h2,
      DPMB_TOK_WRITE = 3'h3,
      DPMB_TOK_TAKE  = 3'h4
   } dpmb_op_t;

   typedef struct packed {
      dpmb_state_t st;
      dpmb_op_t    op;
      logic        rd_phase;
      logic [7:0]  cnt;
      logic [12:0] addr;
      logic [15:0] wdata;
      logic [15:0] rdata;
      logic [1:0]  lane_en;
      logic        active;
      logic        done;
      logic        owned;
      logic        busy_s1;
      logic        busy_s2;
      logic        flag_s1;
      logic        flag_s2;
      logic [15:0] din_s1;
      logic [15:0] din_s2;
      logic [15:0] rd_data;
      logic        chip_sel_n;
      logic        token_select_n;
      logic        rw_n;
      logic        out_en_n;
      logic        upper_lane_select_n;
      logic        lower_lane_select_n;
      logic [15:0] dq_o;
      logic        dq_oe_n;
   } dpmb_regs_t;

endpackage : dpmb_pkg

// file: testbench/dpmb_host_chk.sv
// Pin-level assertions for the memory port controller.
// Assumes a bind to the controller top, ports by name.
`timescale 1ns/10ps
module dpmb_host_chk (
   input wire logic        clk,
   input wire logic        arst_n,
   input wire logic [12:0] mem_addr,
   input wire logic        chip_sel_n,
   input wire logic        token_select_n,
   input wire logic        rw_n,
   input wire logic        out_en_n,
   input wire logic        upper_lane_select_n,
   input wire logic        lower_lane_select_n,
   input wire logic [15:0] dq_o,
   input wire logic        dq_oe_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence s_wr_pulse;
      (!rw_n)[*1] ##1 rw_n;
   endsequence
   sequence s_rd_pulse;
      (!out_en_n)[*5] ##1 out_en_n;
   endsequence
   a_write_len: assert property ($fell(rw_n) |-> s_wr_pulse)
      else $error("write strobe length wrong");
   a_write_data: assert property (!rw_n |-> !dq_oe_n && $stable(dq_o))
      else $error("write data not driven steady");
   a_read_len: assert property ($fell(out_en_n) && !chip_sel_n |-> s_rd_pulse)
      else $error("read enable length wrong");
   a_read_sel: assert property (!out_en_n |-> rw_n && dq_oe_n && !(chip_sel_n && token_select_n))
      else $error("read without select or with drive");
   a_sel_excl: assert property (chip_sel_n || token_select_n)
      else $error("both selects low");
   a_tok_lanes: assert property (!token_select_n |-> upper_lane_select_n && lower_lane_select_n)
      else $error("lane select low in token access");
   a_tok_addr: assert property (!token_select_n |-> mem_addr[12:3] == 10'h000)
      else $error("token address high bits set");
   a_tok_gap: assert property ($rose(rw_n) && !token_select_n |=> token_select_n)
      else $error("no gap after token write");
endmodule : dpmb_host_chk

// file: testbench/dpmb_mem_model.sv
// Behavioural model of one memory port; bench plays the far port.
// Assumes far_post, far_tok and busy_n come from the bench.
`timescale 1ns/10ps
module dpmb_mem_model (
   input  wire logic        clk,
   input  wire logic [12:0] mem_addr,
   input  wire logic        chip_sel_n,
   input  wire logic        token_select_n,
   input  wire logic        rw_n,
   input  wire logic        out_en_n,
   input  wire logic        upper_lane_select_n,
   input  wire logic        lower_lane_select_n,
   input  wire logic [15:0] dq_o,
   input  wire logic        busy_n,
   input  wire logic        far_post,
   input  wire logic [7:0]  far_tok,
   output      logic [15:0] dq_i = 16'h5A5A,
   output      logic        flag_n = 1'b1
);
   logic [15:0] mem [0:8191];
   logic [15:0] tok_q = 16'hFFFF;
   logic [7:0]  own = 8'h00;
   logic [7:0]  req = 8'h00;
   logic [2:0]  ti;
   assign ti = mem_addr[2:0];
   // Write ends on whichever strobe rises first
   always @(posedge rw_n or posedge chip_sel_n) begin
      if (chip_sel_n != rw_n) begin
         if (!lower_lane_select_n) mem[mem_addr][7:0] <= dq_o[7:0];
         if (!upper_lane_select_n) mem[mem_addr][15:8] <= dq_o[15:8];
      end else if (!token_select_n && rw_n) begin
         if (dq_o[0]) begin
            own[ti] <= 1'b0;
            req[ti] <= 1'b0;
         end else if (far_tok[ti]) req[ti] <= 1'b1;
         else own[ti] <= 1'b1;
      end
   end
   always @(negedge out_en_n or posedge far_post) begin
      if (far_post) flag_n <= 1'b0;
      else begin
         tok_q <= {16{~(own[ti] | req[ti] & ~far_tok[ti])}};
         if (!chip_sel_n && mem_addr == 13'h1FFE && busy_n) flag_n <= 1'b1;
      end
   end
   // Released lines toggle so a stale value is never trusted
   always @(posedge clk) begin
      if (!out_en_n && !token_select_n) dq_i <= tok_q;
      else if (!out_en_n && !chip_sel_n) dq_i <= mem[mem_addr];
      else dq_i <= ~dq_i;
   end
endmodule : dpmb_mem_model

// file: testbench/test_dpmb_host.sv
// Self-checking bench for the memory port controller.
// Assumes the memory model and checker are compiled first.
`timescale 1ns/10ps
`include "dpmb_params.svh"
module test_dpmb_host;
   logic        clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, far_post = 0, rd_q = 0;
   logic        busy_n = 1;
   logic [2:0]  reg_addr = 0;
   logic [7:0]  far_tok = 0;
   logic [12:0] a, mem_addr;
   logic [15:0] reg_wdata = 0, v, m, d1, d2, reg_rdata, dq_i, dq_o;
   logic        chip_sel_n, token_select_n, rw_n, out_en_n, dq_oe_n, flag_n;
   logic        upper_lane_select_n, lower_lane_select_n;
   logic [15:0] exp_q[$], msk_q[$];
   int          bad_count = 0, tests_run = 0;
   always #20 clk = ~clk;
   dpmb_host dut (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .mem_addr, .chip_sel_n, .token_select_n, .rw_n, .out_en_n, .upper_lane_select_n,
      .lower_lane_select_n, .dq_i, .dq_o, .dq_oe_n, .busy_n, .flag_n);
   dpmb_mem_model mem (.clk, .mem_addr, .chip_sel_n, .token_select_n, .rw_n, .out_en_n,
      .upper_lane_select_n, .lower_lane_select_n, .dq_o, .busy_n, .far_post, .far_tok,
      .dq_i, .flag_n);
   task chk(input string n, input logic [15:0] s, input logic [15:0] e);
      tests_run++;
      if (s !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task test_done;
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : test_done
   task wr(input logic [2:0] ad, input logic [15:0] d);
      reg_addr <= ad;
      reg_wdata <= d;
      reg_wr <= 1;
      @(posedge clk);
      reg_wr <= 0;
      @(posedge clk);
   endtask : wr
   task rd(input logic [2:0] ad, input logic [15:0] e, input logic [15:0] k);
      reg_addr <= ad;
      reg_rd <= 1;
      @(posedge clk);
      reg_rd <= 0;
      exp_q.push_back(e);
      msk_q.push_back(k);
      @(posedge clk);
      v = reg_rdata;
   endtask : rd
   task go(input logic [2:0] o, input logic [1:0] ln, input logic [12:0] ad,
      input logic [15:0] d);
      wr(`DPMB_REG_ADDR, {3'h0, ad});
      wr(`DPMB_REG_WDATA, d);
      wr(`DPMB_REG_CTRL, {10'h000, ln, 1'b0, o});
   endtask : go
   task fin;
      int n;
      n = 0;
      v = 16'h0000;
      while (v[`DPMB_ST_DONE] !== 1'b1 && n < 200) begin
         rd(`DPMB_REG_STATUS, 16'h0000, 16'h0000);
         n++;
      end
      if (n >= 200) bad_count++;
   endtask : fin
   task op(input logic [2:0] o, input logic [1:0] ln, input logic [12:0] ad,
      input logic [15:0] d);
      go(o, ln, ad, d);
      fin;
   endtask : op
   always @(posedge clk) begin
      if (rd_q) begin
         m = msk_q.pop_front();
         chk("reg_rdata", reg_rdata & m, exp_q.pop_front() & m);
      end
      rd_q <= reg_rd;
   end
   initial begin
      repeat (50000) @(posedge clk);
      bad_count++;
      test_done;
   end
   initial begin
      v = $urandom(32'h9FF31777);
      repeat (12) @(posedge clk);
      arst_n <= 1;
      @(posedge clk);
      chk("pins", {9'h000, chip_sel_n, token_select_n, rw_n, out_en_n,
         upper_lane_select_n, lower_lane_select_n, dq_oe_n}, 16'h007F);
      repeat (4) begin
         a = 13'($urandom_range(8189));
         d1 = 16'($urandom);
         d2 = 16'($urandom);
         op(3'h1, 2'h3, a, d1);
         op(3'h1, 2'h1, a, d2);
         op(3'h0, 2'h3, a, 16'h0000);
         rd(`DPMB_REG_RDATA, {d1[15:8], d2[7:0]}, 16'hFFFF);
      end
      far_post <= 1;
      @(posedge clk);
      far_post <= 0;
      repeat (4) @(posedge clk);
      rd(`DPMB_REG_STATUS, 16'h0010, 16'h0010);
      op(3'h0, 2'h3, 13'h1FFF, 16'h0000);
      rd(`DPMB_REG_STATUS, 16'h0010, 16'h0010);
      busy_n <= 0;
      op(3'h0, 2'h3, 13'h1FFE, 16'h0000);
      rd(`DPMB_REG_STATUS, 16'h0018, 16'h0018);
      busy_n <= 1;
      op(3'h0, 2'h3, 13'h1FFE, 16'h0000);
      rd(`DPMB_REG_STATUS, 16'h0000, 16'h0018);
      busy_n <= 0;
      go(3'h1, 2'h3, 13'h0100, 16'hA5C3);
      repeat (20) @(posedge clk);
      chk("rw_n", {15'h0000, rw_n}, 16'h0001);
      busy_n <= 1;
      fin;
      op(3'h0, 2'h3, 13'h0100, 16'h0000);
      rd(`DPMB_REG_RDATA, 16'hA5C3, 16'hFFFF);
      far_tok <= 8'h08;
      for (int i = 0; i < 8; i++) begin
         a = {10'($urandom), 3'(i)};
         op(i == 3 ? 3'h3 : 3'h4, 2'h0, a, 16'h0000);
         op(3'h2, 2'h0, a, 16'h0000);
         rd(`DPMB_REG_STATUS, i == 3 ? 16'h0000 : 16'h0004, 16'h0004);
         rd(`DPMB_REG_RDATA, i == 3 ? 16'hFFFF : 16'h0000, 16'hFFFF);
      end
      far_tok <= 8'h00;
      op(3'h2, 2'h0, 13'h0003, 16'h0000);
      rd(`DPMB_REG_STATUS, 16'h0004, 16'h0004);
      op(3'h3, 2'h0, 13'h0003, 16'h0001);
      op(3'h2, 2'h0, 13'h0003, 16'h0000);
      rd(`DPMB_REG_RDATA, 16'hFFFF, 16'hFFFF);
      repeat (4) @(posedge clk);
      test_done;
   end
endmodule : test_dpmb_host
bind dpmb_host dpmb_host_chk chk (.clk, .arst_n, .mem_addr, .chip_sel_n, .token_select_n,
   .rw_n, .out_en_n, .upper_lane_select_n, .lower_lane_select_n, .dq_o, .dq_oe_n);
